// *** hw/mcf_defs.vh ***
// constants for the measuring control and feedback register bank
// assumes a 20 MHz system clock and an 8-bit word-aligned register port
`ifndef MCF_DEFS_VH
`define MCF_DEFS_VH

// register byte addresses
`define MCF_ADDR_CTRL      8'h00
`define MCF_ADDR_VALUE     8'h04
`define MCF_ADDR_STATUS    8'h08
`define MCF_ADDR_MEAS      8'h0c
`define MCF_ADDR_LOW       8'h10
`define MCF_ADDR_HIGH      8'h14
`define MCF_ADDR_CONFIG    8'h18

// control word field positions
`define MCF_C_SOFT_GATE    0
`define MCF_C_CLR_REQ      2
`define MCF_C_A_LEVEL      3
`define MCF_C_A_EN         4
`define MCF_C_B_LEVEL      5
`define MCF_C_B_EN         6
`define MCF_C_ERR_ACK      7
`define MCF_C_LOAD_LOW     8
`define MCF_C_LOAD_HIGH    9
`define MCF_C_CHG_INT      10
`define MCF_C_CHG_FUNC     12

// status word field positions
`define MCF_S_LOAD_BUSY    0
`define MCF_S_LOAD_FAULT   1
`define MCF_S_CLR_ACT      2
`define MCF_S_ERR_LO       3
`define MCF_S_CFG_FAULT    7
`define MCF_S_GATE         8
`define MCF_S_AUX          9
`define MCF_S_OUT_A        11
`define MCF_S_OUT_B        12
`define MCF_S_DONE         19
`define MCF_S_ABOVE        21
`define MCF_S_BELOW        22

// reset values
`define MCF_RST_INTERVAL   16'h0001
`define MCF_RST_LOW        32'h00000000
`define MCF_RST_HIGH       32'hffffffff
`define MCF_RST_FUNC       2'h0

// value ranges
`define MCF_INT_MIN        16'h0001
`define MCF_INT_MAX        16'h2ee0

// output a functions
`define MCF_FN_PLAIN       2'h0
`define MCF_FN_OUTSIDE     2'h1
`define MCF_FN_BELOW       2'h2
`define MCF_FN_ABOVE       2'h3

// timing: interval unit and handshake length
`define MCF_CLK_HZ         20000000
`define MCF_UNIT_MS        10
`define MCF_UNIT_CYCLES    ((`MCF_CLK_HZ / 1000) * `MCF_UNIT_MS)
`define MCF_HS_CYCLES      3'h4

`endif

// *** hw/mcf_ctrl_feedback.v ***
// control and feedback register bank for a single-channel measuring unit
// assumes one 20 MHz clock, synchronous active-high reset, a plain
// register port with read data one cycle after the read strobe, and
// measuring logic on the same clock that delivers raw values
//
// Functional notes
// (R1) change-function request adopts byte 0 function
// (R2) change-interval request adopts bytes 0-1, next measurement
// (R3) load-high request adopts 32-bit high limit
// (R4) load-low request adopts 32-bit low limit
// (R5) output a level gated by its enable
// (R6) output b level gated by its enable
// (R7) error flags held until acknowledged, cause gone
// (R8) separate supply, output a/b, sensor error flags
// (R9) several requests at once raise load fault
// (R10) out-of-range value rejected, load fault set
// (R11) status cleared by request/active handshake
// (R12) measured value refreshed each interval end
// (R13) integration mode sets done per interval
// (R14) continuous mode sets done only for real values
// (R15) done cleared only by status-clear handshake
// (R16) aux input level always reported
// (R17) soft gate follows its control bit
// (R18) limit flags set on violation, cleared by handshake
// (R19) gate-open shown while gate open and measuring
// (R20) load-busy shown while a request is processed
// (R21) configuration fault flag reported
// (R22) clear-active drops when request withdrawn
// (R23) load fault stays until a correct transfer
// (R24) handshakes complete in exactly four cycles
// (R25) ack held or master stopped: flags follow faults
// (R26) output a function two-bit encoding
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "mcf_defs.vh"

module mcf_ctrl_feedback #(
   parameter [31:0] UNIT_CYCLES = `MCF_UNIT_CYCLES  // cycles per interval unit
) (
   // clock and reset
   input  wire        i_sys_clk,
   input  wire        i_reset,
   // register port
   input  wire [7:0]  i_addr,
   input  wire [31:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [31:0] o_rdata,
   // pins from the field side
   input  wire        i_aux_input,
   input  wire        i_sensor_supply_fault,
   input  wire        i_out_a_fault,
   input  wire        i_out_b_fault,
   input  wire        i_sensor_fault,
   // measuring logic and system state
   input  wire [31:0] i_meas_value,
   input  wire        i_meas_estimated,
   input  wire        i_continuous,
   input  wire        i_config_fault,
   input  wire        i_master_stop,
   // outputs
   output reg         o_output_a,
   output reg         o_output_b,
   output reg         o_soft_gate,
   output reg         o_gate_open,
   output reg         o_meas_end,
   output reg  [15:0] o_interval,
   output reg  [1:0]  o_out_a_function
);

   // load sequencer states
   localparam [2:0] LD_IDLE = 3'h1;
   localparam [2:0] LD_BUSY = 3'h2;
   localparam [2:0] LD_DONE = 3'h4;

   reg  [12:0] ctrl_q;           // control word
   reg  [31:0] value_q;          // value field
   reg  [31:0] low_q;            // low limit
   reg  [31:0] high_q;           // high limit
   reg  [31:0] meas_q;           // last measured value
   reg  [2:0]  ld_state_q;       // load sequencer
   reg  [2:0]  ld_cnt_q;         // load cycle count
   reg         load_fault_q;     // load fault flag
   reg  [2:0]  clr_cnt_q;        // clear handshake count
   reg         clr_act_q;        // status clear active
   reg         done_q;           // measurement done
   reg         above_q;          // high limit violated
   reg         below_q;          // low limit violated
   reg         cfg_fault_q;      // configuration fault
   reg  [3:0]  err_q;            // supply, out a, out b, sensor
   reg  [31:0] pre_q;            // unit prescaler
   reg  [15:0] unit_cnt_q;       // units elapsed
   reg  [15:0] cur_int_q;        // interval of running measurement
   wire [3:0]  req;              // four load/change requests
   wire        req_any;          // any request present
   wire        req_multi;        // more than one request
   reg         val_ok;           // offered value in range
   wire        unit_tick;        // one interval unit elapsed
   wire        meas_end;         // measurement ends now
   wire        hit_above;        // value over high limit
   wire        hit_below;        // value under low limit
   wire [4:0]  pin_raw;          // raw pin inputs
   wire [4:0]  pin_s;            // filtered pin levels
   wire        clr_fire;         // clear handshake completes now

   // pin synchronisers, three stages, change when stages 2 and 3 agree
   assign pin_raw = {i_aux_input, i_sensor_fault, i_out_b_fault,
                     i_out_a_fault, i_sensor_supply_fault};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
         reg s1_q;   // first stage, read by s2 only
         reg s2_q;   // second stage
         reg s3_q;   // third stage
         reg lvl_q;  // accepted level
         always @(posedge i_sys_clk) begin
            if (i_reset) begin
               s1_q  <= 1'b0;
               s2_q  <= 1'b0;
               s3_q  <= 1'b0;
               lvl_q <= 1'b0;
            end else begin
               s1_q <= pin_raw[gi];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  lvl_q <= s3_q;
               end
            end
         end
         assign pin_s[gi] = lvl_q;
      end
   endgenerate

   // error flags: sticky, cleared by ack once the cause is gone
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_err
         always @(posedge i_sys_clk) begin
            if (i_reset) begin
               err_q[gi] <= 1'b0;
            end else if (pin_s[gi]) begin
               err_q[gi] <= 1'b1;                        // [R8]
            end else if (ctrl_q[`MCF_C_ERR_ACK] || i_master_stop) begin
               err_q[gi] <= 1'b0;                        // [R7] [R25]
            end
         end
      end
   endgenerate

   // configuration fault tracks the parameter checker
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         cfg_fault_q <= 1'b0;
      end else begin
         cfg_fault_q <= i_config_fault;                  // [R21]
      end
   end

   // request decode and value range check
   assign req = {ctrl_q[`MCF_C_CHG_FUNC], ctrl_q[`MCF_C_CHG_INT],
                 ctrl_q[`MCF_C_LOAD_HIGH], ctrl_q[`MCF_C_LOAD_LOW]};
   assign req_any   = |req;
   assign req_multi = (req != 4'h0) && ((req & (req - 4'h1)) != 4'h0);

   // range of the value for the single active request
   always @* begin
      val_ok = 1'b0;
      case (req)
         4'h1: val_ok = (value_q < high_q);  // [R10]
         4'h2: val_ok = (value_q > low_q);  // [R10]
         4'h4: val_ok = (value_q[31:16] == 16'h0000) &&
                        (value_q[15:0] >= `MCF_INT_MIN) &&
                        (value_q[15:0] <= `MCF_INT_MAX);  // [R10]
         4'h8: val_ok = (value_q[31:2] == 30'h00000000);  // [R10]
         default: val_ok = 1'b0;
      endcase
   end

   // load sequencer: busy for four cycles, then adopt or reject
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         ld_state_q       <= LD_IDLE;
         ld_cnt_q         <= 3'h0;
         load_fault_q     <= 1'b0;
         low_q            <= `MCF_RST_LOW;
         high_q           <= `MCF_RST_HIGH;
         o_interval       <= `MCF_RST_INTERVAL;
         o_out_a_function <= `MCF_RST_FUNC;
      end else begin
         case (ld_state_q)
            LD_IDLE: begin
               if (req_any) begin
                  ld_state_q <= LD_BUSY;
                  ld_cnt_q   <= 3'h1;
               end
            end
            LD_BUSY: begin
               if (!req_any) begin
                  ld_state_q <= LD_IDLE;                 // request withdrawn
               end else if (ld_cnt_q == `MCF_HS_CYCLES) begin   // [R24]
                  ld_state_q <= LD_DONE;
                  if (req_multi || !val_ok) begin
                     load_fault_q <= 1'b1;  // [R9] [R10]
                  end else begin
                     load_fault_q <= 1'b0;  // [R23]
                     case (req)
                        4'h1: low_q <= value_q;  // [R4]
                        4'h2: high_q <= value_q;  // [R3]
                        4'h4: o_interval <= value_q[15:0];  // [R2]
                        default: o_out_a_function <= value_q[1:0];  // [R1] [R26]
                     endcase
                  end
               end else begin
                  ld_cnt_q <= ld_cnt_q + 3'h1;
               end
            end
            LD_DONE: begin
               if (req_multi) begin
                  load_fault_q <= 1'b1;                  // [R23]
               end
               if (!req_any) begin
                  ld_state_q <= LD_IDLE;                 // wait for release
               end
            end
            default: begin
               ld_state_q <= LD_IDLE;
            end
         endcase
      end
   end

   // interval timer: runs while the soft gate is open
   assign unit_tick = o_soft_gate && (pre_q == UNIT_CYCLES - 32'h1);
   assign meas_end  = unit_tick && (unit_cnt_q + 16'h1 >= cur_int_q);

   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         pre_q      <= 32'h0;
         unit_cnt_q <= 16'h0;
         cur_int_q  <= `MCF_RST_INTERVAL;
         o_meas_end <= 1'b0;
      end else begin
         o_meas_end <= meas_end;
         if (!o_soft_gate) begin
            pre_q      <= 32'h0;
            unit_cnt_q <= 16'h0;
            cur_int_q  <= o_interval;                    // start with latest
         end else if (unit_tick) begin
            pre_q <= 32'h0;
            if (meas_end) begin
               unit_cnt_q <= 16'h0;
               cur_int_q  <= o_interval;                 // [R2]
            end else begin
               unit_cnt_q <= unit_cnt_q + 16'h1;
            end
         end else begin
            pre_q <= pre_q + 32'h1;
         end
      end
   end

   // measured value and limit compare
   assign hit_above = (i_meas_value > high_q);
   assign hit_below = (i_meas_value < low_q);

   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         meas_q <= 32'h0;
      end else if (meas_end) begin
         meas_q <= i_meas_value;                         // [R12]
      end
   end

   // status clear handshake, four cycles to active
   assign clr_fire = ctrl_q[`MCF_C_CLR_REQ] && !clr_act_q &&
                     (clr_cnt_q == `MCF_HS_CYCLES - 3'h1);

   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         clr_cnt_q <= 3'h0;
         clr_act_q <= 1'b0;
      end else if (!ctrl_q[`MCF_C_CLR_REQ]) begin
         clr_cnt_q <= 3'h0;
         clr_act_q <= 1'b0;                              // [R22]
      end else if (clr_fire) begin
         clr_act_q <= 1'b1;  // [R11] [R24]
      end else if (!clr_act_q) begin
         clr_cnt_q <= clr_cnt_q + 3'h1;
      end
   end

   // sticky status: a new event wins over the clear
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         done_q  <= 1'b0;
         above_q <= 1'b0;
         below_q <= 1'b0;
      end else begin
         if (meas_end && (!i_continuous || !i_meas_estimated)) begin
            done_q <= 1'b1;  // [R13] [R14]
         end else if (clr_fire) begin
            done_q <= 1'b0;  // [R15]
         end
         if (meas_end && hit_above) begin
            above_q <= 1'b1;  // [R18]
         end else if (clr_fire) begin
            above_q <= 1'b0;  // [R18]
         end
         if (meas_end && hit_below) begin
            below_q <= 1'b1;  // [R18]
         end else if (clr_fire) begin
            below_q <= 1'b0;  // [R18]
         end
      end
   end

   // digital outputs, soft gate and gate status
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_output_a  <= 1'b0;
         o_output_b  <= 1'b0;
         o_soft_gate <= 1'b0;
         o_gate_open <= 1'b0;
      end else begin
         o_soft_gate <= ctrl_q[`MCF_C_SOFT_GATE];         // [R17]
         o_gate_open <= o_soft_gate && ctrl_q[`MCF_C_SOFT_GATE];  // [R19]
         o_output_b  <= ctrl_q[`MCF_C_B_EN] && ctrl_q[`MCF_C_B_LEVEL];  // [R6]
         case (o_out_a_function)
            `MCF_FN_PLAIN: begin
               o_output_a <= ctrl_q[`MCF_C_A_EN] &&
                             ctrl_q[`MCF_C_A_LEVEL];     // [R5]
            end
            `MCF_FN_OUTSIDE: begin
               o_output_a <= ctrl_q[`MCF_C_A_EN] &&
                             (above_q || below_q);       // [R26]
            end
            `MCF_FN_BELOW: o_output_a <= ctrl_q[`MCF_C_A_EN] && below_q;  // [R26]
            default: o_output_a <= ctrl_q[`MCF_C_A_EN] && above_q;  // [R26]
         endcase
      end
   end

   // register writes
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         ctrl_q  <= 13'h0;
         value_q <= 32'h0;
      end else if (i_wr) begin
         if (i_addr == `MCF_ADDR_CTRL) ctrl_q <= i_wdata[12:0] & 13'h17fd;  // reserved bits zero
         if (i_addr == `MCF_ADDR_VALUE) value_q <= i_wdata;
      end
   end

   // register reads, data valid the cycle after the strobe
   always @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_rdata <= 32'h0;
      end else if (i_rd) begin
         case (i_addr)
            `MCF_ADDR_CTRL: o_rdata <= {19'h0, ctrl_q};
            `MCF_ADDR_VALUE: o_rdata <= value_q;
            `MCF_ADDR_STATUS: begin
               o_rdata <= {9'h0, below_q, above_q, 1'b0, done_q,
                           6'h0, o_output_b, o_output_a, 1'b0,
                           pin_s[4],                     // [R16]
                           o_gate_open, cfg_fault_q, err_q,
                           clr_act_q, load_fault_q,
                           (ld_state_q == LD_BUSY)};     // [R20]
            end
            `MCF_ADDR_MEAS: o_rdata <= meas_q;
            `MCF_ADDR_LOW: o_rdata <= low_q;
            `MCF_ADDR_HIGH: o_rdata <= high_q;
            `MCF_ADDR_CONFIG: o_rdata <= {14'h0, o_out_a_function, o_interval};
            default: o_rdata <= 32'h0;  // unmapped
         endcase
      end else begin
         o_rdata <= 32'h0;
      end
   end

endmodule

`default_nettype wire

// *** dv/mcf_monitor.sv ***
// checker for the measuring control and feedback bank
// assumes it is bound onto mcf_ctrl_feedback, one clock domain
`timescale 1ns/100ps
`default_nettype none
`include "mcf_defs.vh"

module mcf_monitor (
   // clock and reset
   input wire logic        i_sys_clk,
   input wire logic        i_reset,
   // register port
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   // pins and outputs
   input wire logic        i_aux_input,
   input wire logic        o_output_b,
   input wire logic        o_soft_gate,
   input wire logic        o_gate_open,
   input wire logic        o_meas_end,
   input wire logic [15:0] o_interval,
   input wire logic [1:0]  o_out_a_function
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_reset);

   // control write, then two quiet cycles for the output stage
   sequence s_ctl_settled;
      i_wr && i_addr == `MCF_ADDR_CTRL ##1 !i_wr [*2];
   endsequence
   // aux pin steady past its filter, then a status read
   sequence s_aux_read;
      $stable(i_aux_input) [*6] ##0 i_rd && i_addr == `MCF_ADDR_STATUS;
   endsequence

   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data not zero outside its cycle");
   a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) > 8'h18 |-> o_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_config_mirror: assert property ($past(i_rd) && $past(i_addr) == `MCF_ADDR_CONFIG
      |-> o_rdata == {14'h0, $past(o_out_a_function), $past(o_interval)})
      else $error("config word differs from adopted settings");
   a_aux_status: assert property (s_aux_read |=> o_rdata[`MCF_S_AUX] == $past(i_aux_input))
      else $error("aux level not reported");
   a_soft_gate: assert property (s_ctl_settled
      |-> o_soft_gate == $past(i_wdata[`MCF_C_SOFT_GATE], 2))
      else $error("soft gate does not follow control bit");
   a_out_b_gated: assert property (s_ctl_settled |-> o_output_b ==
      ($past(i_wdata[`MCF_C_B_EN], 2) && $past(i_wdata[`MCF_C_B_LEVEL], 2)))
      else $error("output b not gated by its enable");
   a_meas_pulse: assert property (o_meas_end |=> !o_meas_end)
      else $error("measurement end longer than one cycle");
   a_gate_follow: assert property (o_gate_open |-> o_soft_gate || $past(o_soft_gate))
      else $error("gate open while soft gate closed");
   a_reset_values: assert property ($fell(i_reset) |-> o_interval == `MCF_RST_INTERVAL
      && o_out_a_function == `MCF_RST_FUNC && !o_soft_gate && !o_output_b)
      else $error("outputs not at reset values");
endmodule

bind mcf_ctrl_feedback mcf_monitor u_mon (
   .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_aux_input(i_aux_input),
   .o_output_b(o_output_b), .o_soft_gate(o_soft_gate), .o_gate_open(o_gate_open),
   .o_meas_end(o_meas_end), .o_interval(o_interval), .o_out_a_function(o_out_a_function));

`default_nettype wire

// *** dv/mcf_plc_model.sv ***
// bus master model standing for the cyclic process-data master
// assumes the bank answers reads one cycle after the strobe, no stall
`timescale 1ns/100ps
`default_nettype none

module mcf_plc_model (
   // clock and reset
   input wire logic         i_sys_clk,
   input wire logic         i_reset,
   // request from the bench
   input wire logic         i_go,
   input wire logic         i_is_rd,
   input wire logic [7:0]   i_a,
   input wire logic [31:0]  i_d,
   output var logic         o_done = 1'b0,
   output var logic [31:0]  o_data = 32'h0,
   // register port
   output var logic [7:0]   o_addr = 8'h0,
   output var logic [31:0]  o_wdata = 32'h0,
   output var logic         o_wr = 1'b0,
   output var logic         o_rd = 1'b0,
   input wire logic [31:0]  i_rdata
);
   logic pend_q = 1'b0;  // strobe taken, answer due

   // one access at a time; idle lines show a moving pattern
   always @(posedge i_sys_clk) begin
      o_done <= 1'b0;
      o_addr <= ~o_addr;
      o_wdata <= ~o_wdata;
      if (i_reset) begin
         o_wr <= 1'b0;
         o_rd <= 1'b0;
         pend_q <= 1'b0;
      end else if (o_wr || o_rd) begin
         // strobe lasts one cycle
         o_wr <= 1'b0;
         o_rd <= 1'b0;
         pend_q <= 1'b1;
      end else if (pend_q) begin
         // read data stands only in this cycle
         o_data <= i_rdata;
         o_done <= 1'b1;
         pend_q <= 1'b0;
      end else if (i_go) begin
         o_addr <= i_a;
         o_wdata <= i_d;
         o_wr <= !i_is_rd;
         o_rd <= i_is_rd;
      end
   end
endmodule

`default_nettype wire

// *** dv/measure_ctrl_feedback_if_test.sv ***
// self-checking bench for the measuring control and feedback bank
// assumes the plc model drives the register port, 50 ns clock
`timescale 1ns/100ps
`default_nettype none
`include "mcf_defs.vh"

module measure_ctrl_feedback_if_test;
   localparam logic [7:0] A_CT = `MCF_ADDR_CTRL;   // control word
   localparam logic [7:0] A_VL = `MCF_ADDR_VALUE;  // value field
   localparam logic [7:0] A_ST = `MCF_ADDR_STATUS; // status word
   logic        i_sys_clk = 1'b0;           // system clock
   logic        i_reset = 1'b1;             // sync reset
   logic        go = 1'b0, is_rd = 1'b0;    // model request
   logic [7:0]  a = 8'h0;                   // request address
   logic [31:0] d = 32'h0, v, meas = 32'h0; // request data, result, measurement
   logic        aux = 1'b0, cont = 1'b0, est = 1'b0, cfg = 1'b0, stop = 1'b0;
   logic [3:0]  flt = 4'h0;                 // supply, out a, out b, sensor
   logic        seen_open;                  // gate open seen while waiting
   wire  [7:0]  addr;
   wire  [31:0] wdata, rdata, mdata;
   wire         wr, rd, done, out_a, out_b, sgate, gopen, mend;
   wire  [15:0] intv;
   wire  [1:0]  func;
   int          bad_count = 0, checks = 0;

   initial forever #25 i_sys_clk = ~i_sys_clk;

   mcf_plc_model u_plc (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_go(go), .i_is_rd(is_rd),
      .i_a(a), .i_d(d), .o_done(done), .o_data(mdata), .o_addr(addr), .o_wdata(wdata),
      .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
   mcf_ctrl_feedback #(.UNIT_CYCLES(32'h4)) dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_aux_input(aux), .i_sensor_supply_fault(flt[0]), .i_out_a_fault(flt[1]),
      .i_out_b_fault(flt[2]), .i_sensor_fault(flt[3]), .i_meas_value(meas),
      .i_meas_estimated(est), .i_continuous(cont), .i_config_fault(cfg),
      .i_master_stop(stop), .o_output_a(out_a), .o_output_b(out_b), .o_soft_gate(sgate),
      .o_gate_open(gopen), .o_meas_end(mend), .o_interval(intv), .o_out_a_function(func));

   // verdict and end of run
   task tally_and_finish;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task timeout;
      bad_count++;
      tally_and_finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   // one access through the master model, bounded wait
   task bus(input logic r, input logic [7:0] ad, input logic [31:0] dv);
      int k;
      @(posedge i_sys_clk);
      go <= 1'b1;
      is_rd <= r;
      a <= ad;
      d <= dv;
      @(posedge i_sys_clk);
      go <= 1'b0;
      for (k = 0; k < 20 && done !== 1'b1; k++) cyc(1);
      if (done !== 1'b1) timeout;
      v = mdata;
   endtask
   task chk(input logic [7:0] ad, input logic [31:0] e);
      bus(1'b1, ad, 32'h0);
      check(v, e);
   endtask
   task sbit(input int b, input logic e);
      bus(1'b1, A_ST, 32'h0);
      check({31'h0, v[b]}, {31'h0, e});
   endtask
   // value then request, hold, withdraw
   task load(input int b, input logic [31:0] val);
      bus(1'b0, A_VL, val);
      bus(1'b0, A_CT, 32'h1 << b);
      sbit(0, 1'b1);
      bus(1'b0, A_CT, 32'h0);
      cyc(2);
   endtask
   // status clear handshake, then withdraw
   task clear_sts(input logic [31:0] base);
      int k;
      bus(1'b0, A_CT, base | 32'h4);
      for (k = 0; k < 20; k++) begin
         bus(1'b1, A_ST, 32'h0);
         if (v[2] === 1'b1) break;
      end
      check({31'h0, v[2]}, 32'h1);
      bus(1'b0, A_CT, base);
      sbit(2, 1'b0);
   endtask
   task wait_end;
      int k;
      seen_open = 1'b0;
      for (k = 0; k < 200 && mend !== 1'b1; k++) begin
         cyc(1);
         if (gopen === 1'b1) seen_open = 1'b1;
      end
      if (mend !== 1'b1) timeout;
   endtask
   task gated_run(input logic [31:0] base);
      bus(1'b0, A_CT, base | 32'h1);
      wait_end;
      bus(1'b0, A_CT, base);
   endtask

   task t_reset;
      chk(`MCF_ADDR_CONFIG, 32'h1);
      chk(`MCF_ADDR_LOW, 32'h0);
      chk(`MCF_ADDR_HIGH, 32'hffffffff);
      chk(8'h1c, 32'h0);
      chk(A_ST, 32'h0);
   endtask
   task t_loads;
      int f;
      load(8, 32'h5);
      chk(`MCF_ADDR_LOW, 32'h5);
      load(9, 32'h64);
      chk(`MCF_ADDR_HIGH, 32'h64);
      load(10, 32'h2ee0);
      check({16'h0, intv}, 32'h2ee0);
      load(10, 32'h3);
      for (f = 3; f >= 0; f--) begin
         load(12, f);
         check({30'h0, func}, f);
      end
      chk(`MCF_ADDR_CONFIG, 32'h3);
   endtask
   task t_faults;
      bus(1'b0, A_VL, 32'h7);
      bus(1'b0, A_CT, 32'h300);
      cyc(8);
      sbit(1, 1'b1);
      bus(1'b0, A_CT, 32'h0);
      sbit(1, 1'b1);
      chk(`MCF_ADDR_LOW, 32'h5);
      load(10, 32'h0);
      load(10, 32'h2ee1);
      check({16'h0, intv}, 32'h3);
      load(8, 32'hc8);
      chk(`MCF_ADDR_LOW, 32'h5);
      load(8, 32'h6);
      sbit(1, 1'b0);
   endtask
   task t_outputs;
      int k;
      for (k = 0; k < 5; k++) begin
         bus(1'b0, A_CT, (k < 4 ? 32'h28 : 32'h0) | (k[0] << 4) | (k[1] << 6) | (k[2] * 32'h50));
         cyc(2);
         check(out_a, k == 1 || k == 3);
         check(out_b, k == 2 || k == 3);
         sbit(11, k == 1 || k == 3);
      end
   endtask
   task t_meas;
      meas <= 32'h32;
      bus(1'b0, A_CT, 32'h1);
      cyc(2);
      check(sgate, 1'b1);
      wait_end;
      check(seen_open, 1'b1);
      bus(1'b0, A_CT, 32'h0);
      sbit(19, 1'b1);
      sbit(21, 1'b0);
      sbit(22, 1'b0);
      clear_sts(32'h0);
      sbit(19, 1'b0);
      load(12, 3);
      meas <= 32'hc8;
      gated_run(32'h10);
      sbit(21, 1'b1);
      check(out_a, 1'b1);
      clear_sts(32'h10);
      sbit(21, 1'b0);
      check(out_a, 1'b0);
      meas <= 32'h2;
      gated_run(32'h0);
      sbit(22, 1'b1);
      clear_sts(32'h0);
      cont <= 1'b1;
      est <= 1'b1;
      meas <= 32'h32;
      gated_run(32'h0);
      sbit(19, 1'b0);
      est <= 1'b0;
      gated_run(32'h0);
      sbit(19, 1'b1);
      clear_sts(32'h0);
   endtask
   task t_errors;
      int k;
      for (k = 0; k < 4; k++) begin
         flt <= 4'h1 << k;
         cyc(8);
         sbit(3 + k, 1'b1);
         flt <= 4'h0;
         cyc(8);
         sbit(3 + k, 1'b1);
         bus(1'b0, A_CT, 32'h80);
         cyc(2);
         sbit(3 + k, 1'b0);
         flt <= (k == 2) ? 4'h2 : 4'h0;
         stop <= (k == 2);
         cyc(8);
         sbit(4, k == 2);
         flt <= 4'h0;
         cyc(8);
         sbit(4, 1'b0);
         stop <= 1'b0;
         bus(1'b0, A_CT, 32'h0);
      end
      cfg <= 1'b1;
      cyc(4);
      sbit(7, 1'b1);
      aux <= 1'b1;
      cyc(8);
      sbit(9, 1'b1);
      aux <= 1'b0;
      cyc(8);
      sbit(9, 1'b0);
   endtask

   initial begin
      repeat (6) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      t_reset;
      t_loads;
      t_faults;
      t_outputs;
      t_meas;
      t_errors;
      @(posedge i_sys_clk);
      i_reset <= 1'b1;
      cyc(2);
      i_reset <= 1'b0;
      chk(`MCF_ADDR_CONFIG, 32'h1);
      tally_and_finish;
   end
endmodule

`default_nettype wire
